// ===== design/qec_chan_if.sv
`timescale 1ns/1ps
interface qec_chan_if;
    logic src_sel;
    logic mode_updown;
    logic [qec_pkg::FILT_W-1:0] filt_code;
    logic [qec_pkg::CNT_W-1:0] compare;
    logic load;
    logic [qec_pkg::CNT_W-1:0] load_val;
    logic [3:0] diff_in;
    logic [3:0] ttl_in;
    logic [qec_pkg::CNT_W-1:0] count;
    logic match;
    logic gp_level;

    modport ctl (
        output src_sel, mode_updown, filt_code, compare, load, load_val, diff_in, ttl_in,
        input count, match, gp_level
    );
    modport chan (
        input src_sel, mode_updown, filt_code, compare, load, load_val, diff_in, ttl_in,
        output count, match, gp_level
    );
endinterface

// ===== design/qec_channel.sv
`timescale 1ns/1ps
module qec_channel (
    // clock, reset, enable
    input wire logic core_clk,
    input wire logic reset,
    input wire logic ce,
    // control side
    qec_chan_if.chan ch
);
    import qec_pkg::*;

    typedef struct packed {
        logic [3:0] raw;
        logic [3:0] filt;
        logic [3:0][FILT_CNT_W-1:0] fcnt;
        logic [1:0] prev_ab;
        logic [CNT_W-1:0] count;
        logic match;
    } qec_chan_state_t;

    qec_chan_state_t state;
    qec_chan_state_t next_state;
    logic [FILT_CNT_W-1:0] width_cyc;
    logic step;
    logic up;
    logic dn;

    // change must persist (code + 1) * 0.1 us before it is accepted
    assign width_cyc = (FILT_CNT_W'(ch.filt_code) + 1'b1) * FILT_CNT_W'(FILT_UNIT_CYC);

    always_comb begin
        next_state = state;
        step = 1'b0;
        up = 1'b0;
        dn = 1'b0;
        next_state.raw = ch.src_sel ? ch.ttl_in : ch.diff_in;
        for (int i = 0; i < 4; i++) begin
            if (state.raw[i] == state.filt[i]) begin
                next_state.fcnt[i] = '0;
            end else if (state.fcnt[i] + 1'b1 >= width_cyc) begin
                next_state.filt[i] = state.raw[i];
                next_state.fcnt[i] = '0;
            end else begin
                next_state.fcnt[i] = state.fcnt[i] + 1'b1;
            end
        end
        next_state.prev_ab = state.filt[IN_B:IN_A];
        if (ch.mode_updown) begin
            // separate up and down pulse lines; simultaneous edges cancel
            up = state.filt[IN_A] & ~state.prev_ab[0];
            dn = state.filt[IN_B] & ~state.prev_ab[1];
            if (up && dn) begin
                up = 1'b0;
                dn = 1'b0;
            end
        end else begin
            // x4 decode; a double change is a phase error and is dropped
            step = (state.filt[IN_A] ^ state.prev_ab[0]) ^ (state.filt[IN_B] ^ state.prev_ab[1]);
            up = step & (state.filt[IN_A] ^ state.prev_ab[1]);
            dn = step & ~(state.filt[IN_A] ^ state.prev_ab[1]);
        end
        if (state.filt[IN_Z]) begin
            next_state.count = '0;
        end else if (ch.load) begin
            next_state.count = ch.load_val;
        end else if (up) begin
            next_state.count = state.count + 1'b1;
        end else if (dn) begin
            next_state.count = state.count - 1'b1;
        end
        next_state.match = (next_state.count == ch.compare) &&
            (next_state.count != state.count);
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            state <= '0;
        end else if (ce) begin
            state <= next_state;
        end
    end

    assign ch.count = state.count;
    assign ch.match = state.match;
    assign ch.gp_level = state.filt[IN_GP];
endmodule // qec_channel

// ===== design/qec_pkg.sv
package qec_pkg;
    localparam int QEC_NUM_CH = 4;
    localparam int CNT_W = 24;
    localparam int FILT_W = 14;
    localparam int FILT_CNT_W = 18;
    localparam int PERIOD_W = 18;
    localparam int PWIDTH_W = 14;
    localparam int PRE_W = 18;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int STAT_W = QEC_NUM_CH + 1;
    // index of each line in a channel's input group
    localparam int IN_A = 0;
    localparam int IN_B = 1;
    localparam int IN_Z = 2;
    localparam int IN_GP = 3;
    localparam int STAT_TIMER = QEC_NUM_CH;
    // clock and time bases
    localparam int CLK_PERIOD_PS = 5000;
    localparam int FILT_UNIT_NS = 100;
    localparam int FILT_UNIT_CYC = (FILT_UNIT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int PULSE_UNIT_US = 10;
    localparam int PULSE_UNIT_CYC = PULSE_UNIT_US * 1000000 / CLK_PERIOD_PS;
    localparam int TIMER_UNIT_MS = 1;
    localparam int TIMER_UNIT_CYC = TIMER_UNIT_MS * 1000000000 / CLK_PERIOD_PS;
    // code limits: filter 0.1 us .. 1056.1 us, pulse 0 .. 104.45 ms, timer 1 ms .. 200 s
    localparam logic [FILT_W-1:0] FILT_MAX_CODE = 14'h2940;
    localparam logic [PWIDTH_W-1:0] PWIDTH_MAX_CODE = 14'h28CD;
    localparam logic [PERIOD_W-1:0] PERIOD_MIN_CODE = 18'h00001;
    localparam logic [PERIOD_W-1:0] PERIOD_MAX_CODE = 18'h30D40;
    // register byte offsets
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_MASK = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_INPUTS = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_PERIOD = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_PWIDTH = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_COUNT = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_COMPARE = 8'h30;
    localparam logic [ADDR_W-1:0] OFS_FILTER = 8'h40;
    // control register fields
    localparam int CTRL_SRC_LSB = 0;
    localparam int CTRL_MODE_LSB = 4;
    localparam int CTRL_TIMER_EN = 8;
    // values after reset
    localparam logic [PERIOD_W-1:0] RST_PERIOD = 18'h003E8;
    localparam logic [PWIDTH_W-1:0] RST_PWIDTH = 14'h0000;
    localparam logic [FILT_W-1:0] RST_FILT = 14'h0000;
    localparam logic [CNT_W-1:0] RST_COMPARE = 24'h000000;
    localparam logic [STAT_W-1:0] RST_MASK = 5'h00;
endpackage

// ===== design/qec_top.sv
// Function
// - four channels, 24-bit up/down counters
// - quadrature A/B decoding sets count direction
// - per-channel choice of differential or logic input
// - count equals compare: interrupt plus output pulse
// - interval timer interrupt, 1 ms to 200 s
// - per-channel noise filter, 0.1 to 1056.1 us
// - shared match pulse width, 0 to 104.45 ms
// - per-channel general input level readable
// - all events share one interrupt line
//
// Our own choices: the address map and the strobed register port.
`timescale 1ns/1ps
module qec_top #(
    parameter int TIMER_UNIT_CYCLES = qec_pkg::TIMER_UNIT_CYC
) (
    // clock, reset, enable
    input wire logic core_clk,
    input wire logic reset,
    input wire logic ce,
    // register port
    input wire logic [qec_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [qec_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [qec_pkg::DATA_W-1:0] reg_rdata,
    // differential receiver side, one bit per channel
    input wire logic [qec_pkg::QEC_NUM_CH-1:0] diff_phase_a,
    input wire logic [qec_pkg::QEC_NUM_CH-1:0] diff_phase_b,
    input wire logic [qec_pkg::QEC_NUM_CH-1:0] diff_index_clear_input,
    input wire logic [qec_pkg::QEC_NUM_CH-1:0] diff_gp_in,
    // logic-level receiver side, one bit per channel
    input wire logic [qec_pkg::QEC_NUM_CH-1:0] ttl_phase_a,
    input wire logic [qec_pkg::QEC_NUM_CH-1:0] ttl_phase_b,
    input wire logic [qec_pkg::QEC_NUM_CH-1:0] ttl_index_clear_input,
    input wire logic [qec_pkg::QEC_NUM_CH-1:0] ttl_gp_in,
    // outputs
    output logic [qec_pkg::QEC_NUM_CH-1:0] match_out,
    output logic irq
);
    import qec_pkg::*;

    localparam int US_PRE_W = 11;

    typedef struct packed {
        logic [QEC_NUM_CH-1:0] src_sel;
        logic [QEC_NUM_CH-1:0] mode_updown;
        logic timer_en;
        logic [STAT_W-1:0] mask;
        logic [STAT_W-1:0] status;
        logic [PERIOD_W-1:0] period;
        logic [PWIDTH_W-1:0] pwidth;
        logic [QEC_NUM_CH-1:0][CNT_W-1:0] compare;
        logic [QEC_NUM_CH-1:0][FILT_W-1:0] filt;
        logic [PRE_W-1:0] ms_pre;
        logic [PERIOD_W-1:0] ms_cnt;
        logic [US_PRE_W-1:0] us_pre;
        logic [QEC_NUM_CH-1:0][PWIDTH_W-1:0] pcnt;
        logic [QEC_NUM_CH-1:0] pulse;
        logic irq;
        logic [DATA_W-1:0] rdata;
    } qec_top_state_t;

    qec_top_state_t state;
    qec_top_state_t next_state;
    logic [QEC_NUM_CH-1:0] ch_match;
    logic [QEC_NUM_CH-1:0] ch_gp;
    logic [QEC_NUM_CH-1:0][CNT_W-1:0] ch_count;
    logic [QEC_NUM_CH-1:0] ch_load;
    logic [STAT_W-1:0] events;
    logic ms_tick;
    logic us_tick;
    logic [PERIOD_W-1:0] wr_period;
    logic [PWIDTH_W-1:0] wr_pwidth;
    logic [FILT_W-1:0] wr_filt;

    qec_chan_if ch_if[QEC_NUM_CH] ();

    genvar g;
    generate
        for (g = 0; g < QEC_NUM_CH; g++) begin : gen_ch
            assign ch_if[g].src_sel = state.src_sel[g];
            assign ch_if[g].mode_updown = state.mode_updown[g];
            assign ch_if[g].filt_code = state.filt[g];
            assign ch_if[g].compare = state.compare[g];
            assign ch_if[g].load = ch_load[g];
            assign ch_if[g].load_val = reg_wdata[CNT_W-1:0];
            assign ch_if[g].diff_in = {diff_gp_in[g], diff_index_clear_input[g],
                diff_phase_b[g], diff_phase_a[g]};
            assign ch_if[g].ttl_in = {ttl_gp_in[g], ttl_index_clear_input[g],
                ttl_phase_b[g], ttl_phase_a[g]};
            assign ch_match[g] = ch_if[g].match;
            assign ch_gp[g] = ch_if[g].gp_level;
            assign ch_count[g] = ch_if[g].count;
            assign ch_load[g] = reg_wr && (reg_addr == OFS_COUNT + ADDR_W'(g * 4));
            // each channel filters with 0.1 us granularity, ample for 1 MHz inputs
            qec_channel u_channel (
                .core_clk(core_clk),
                .reset(reset),
                .ce(ce),
                .ch(ch_if[g].chan)
            );
        end
    endgenerate

    // writes are clamped so the stored code is always inside its legal range
    always_comb begin
        wr_period = reg_wdata[PERIOD_W-1:0];
        if (reg_wdata[DATA_W-1:PERIOD_W] != '0 || wr_period > PERIOD_MAX_CODE) begin
            wr_period = PERIOD_MAX_CODE;
        end else if (wr_period < PERIOD_MIN_CODE) begin
            wr_period = PERIOD_MIN_CODE;
        end
        wr_pwidth = reg_wdata[PWIDTH_W-1:0];
        if (reg_wdata[DATA_W-1:PWIDTH_W] != '0 || wr_pwidth > PWIDTH_MAX_CODE) begin
            wr_pwidth = PWIDTH_MAX_CODE;
        end
        wr_filt = reg_wdata[FILT_W-1:0];
        if (reg_wdata[DATA_W-1:FILT_W] != '0 || wr_filt > FILT_MAX_CODE) begin
            wr_filt = FILT_MAX_CODE;
        end
    end

    assign ms_tick = state.timer_en && (state.ms_pre == PRE_W'(TIMER_UNIT_CYCLES - 1));
    assign us_tick = (state.us_pre == US_PRE_W'(PULSE_UNIT_CYC - 1));

    always_comb begin
        next_state = state;
        events = '0;
        // register writes
        if (reg_wr) begin
            if (reg_addr == OFS_CTRL) begin
                next_state.src_sel = reg_wdata[CTRL_SRC_LSB +: QEC_NUM_CH];
                next_state.mode_updown = reg_wdata[CTRL_MODE_LSB +: QEC_NUM_CH];
                next_state.timer_en = reg_wdata[CTRL_TIMER_EN];
            end
            if (reg_addr == OFS_MASK) begin
                next_state.mask = reg_wdata[STAT_W-1:0];
            end
            if (reg_addr == OFS_PERIOD) begin
                next_state.period = wr_period;
            end
            if (reg_addr == OFS_PWIDTH) begin
                next_state.pwidth = wr_pwidth;
            end
            for (int i = 0; i < QEC_NUM_CH; i++) begin
                if (reg_addr == OFS_COMPARE + ADDR_W'(i * 4)) begin
                    next_state.compare[i] = reg_wdata[CNT_W-1:0];
                end
                if (reg_addr == OFS_FILTER + ADDR_W'(i * 4)) begin
                    next_state.filt[i] = wr_filt;
                end
            end
        end
        // interval timer; disabling it restarts the period from zero
        if (!state.timer_en) begin
            next_state.ms_pre = '0;
            next_state.ms_cnt = '0;
        end else if (ms_tick) begin
            next_state.ms_pre = '0;
            if (state.ms_cnt + 1'b1 >= state.period) begin
                next_state.ms_cnt = '0;
                events[STAT_TIMER] = 1'b1;
            end else begin
                next_state.ms_cnt = state.ms_cnt + 1'b1;
            end
        end else begin
            next_state.ms_pre = state.ms_pre + 1'b1;
        end
        // free-running 10 us base for the match pulses
        next_state.us_pre = us_tick ? '0 : state.us_pre + 1'b1;
        for (int i = 0; i < QEC_NUM_CH; i++) begin
            events[i] = ch_match[i];
            if (ch_match[i]) begin
                next_state.pulse[i] = 1'b1;
                next_state.pcnt[i] = '0;
            end else if (state.pulse[i]) begin
                // shared base means the first step may be short by up to 10 us
                if (state.pcnt[i] >= state.pwidth) begin
                    next_state.pulse[i] = 1'b0;
                end else if (us_tick) begin
                    next_state.pcnt[i] = state.pcnt[i] + 1'b1;
                end
            end
        end
        // sticky status: read clears, a new event in the same cycle survives
        if (reg_rd && reg_addr == OFS_STATUS) begin
            next_state.status = events;
        end else begin
            next_state.status = state.status | events;
        end
        next_state.irq = |(next_state.status & next_state.mask);
        // read data, valid the cycle after the strobe; unmapped reads give zero
        next_state.rdata = '0;
        if (reg_rd) begin
            unique case (reg_addr)
                OFS_CTRL: begin
                    next_state.rdata[CTRL_SRC_LSB +: QEC_NUM_CH] = state.src_sel;
                    next_state.rdata[CTRL_MODE_LSB +: QEC_NUM_CH] = state.mode_updown;
                    next_state.rdata[CTRL_TIMER_EN] = state.timer_en;
                end
                OFS_STATUS: next_state.rdata[STAT_W-1:0] = state.status;
                OFS_MASK: next_state.rdata[STAT_W-1:0] = state.mask;
                OFS_INPUTS: begin
                    next_state.rdata[QEC_NUM_CH-1:0] = ch_gp;
                    next_state.rdata[2*QEC_NUM_CH-1:QEC_NUM_CH] = state.pulse;
                end
                OFS_PERIOD: next_state.rdata[PERIOD_W-1:0] = state.period;
                OFS_PWIDTH: next_state.rdata[PWIDTH_W-1:0] = state.pwidth;
                default: begin
                    for (int i = 0; i < QEC_NUM_CH; i++) begin
                        if (reg_addr == OFS_COUNT + ADDR_W'(i * 4)) begin
                            next_state.rdata[CNT_W-1:0] = ch_count[i];
                        end
                        if (reg_addr == OFS_COMPARE + ADDR_W'(i * 4)) begin
                            next_state.rdata[CNT_W-1:0] = state.compare[i];
                        end
                        if (reg_addr == OFS_FILTER + ADDR_W'(i * 4)) begin
                            next_state.rdata[FILT_W-1:0] = state.filt[i];
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            state <= '0;
            state.period <= RST_PERIOD;
            state.pwidth <= RST_PWIDTH;
            state.mask <= RST_MASK;
            for (int i = 0; i < QEC_NUM_CH; i++) begin
                state.compare[i] <= RST_COMPARE;
                state.filt[i] <= RST_FILT;
            end
        end else if (ce) begin
            state <= next_state;
        end
    end

    assign reg_rdata = state.rdata;
    assign match_out = state.pulse;
    assign irq = state.irq;
endmodule // qec_top

// ===== verification/qec_enc_model.sv
`timescale 1ns/1ps
module qec_enc_model (
    // clock and selected path per channel
    input wire logic core_clk,
    input wire logic [3:0] src,
    // differential side
    output logic [3:0] diff_phase_a,
    output logic [3:0] diff_phase_b,
    output logic [3:0] diff_index_clear_input,
    output logic [3:0] diff_gp_in,
    // logic-level side
    output logic [3:0] ttl_phase_a,
    output logic [3:0] ttl_phase_b,
    output logic [3:0] ttl_index_clear_input,
    output logic [3:0] ttl_gp_in
);
    // half period of the fastest allowed input rate
    localparam int HOLD = 100;
    logic [3:0] a = 4'h0;
    logic [3:0] b = 4'h0;
    logic [3:0] z = 4'h0;
    logic [3:0] g = 4'h0;
    // the unused path carries swapped phases and inverted levels, so a wrong pick shows
    assign diff_phase_a = (a & ~src) | (b & src);
    assign ttl_phase_a = (a & src) | (b & ~src);
    assign diff_phase_b = (b & ~src) | (a & src);
    assign ttl_phase_b = (b & src) | (a & ~src);
    assign diff_index_clear_input = z ^ src;
    assign ttl_index_clear_input = z ^ ~src;
    assign diff_gp_in = g ^ src;
    assign ttl_gp_in = g ^ ~src;
    task automatic step(input int ch, input bit up);
        @(posedge core_clk);
        if ((a[ch] == b[ch]) == up)
            a[ch] <= ~a[ch];
        else
            b[ch] <= ~b[ch];
        repeat (HOLD) @(posedge core_clk);
    endtask
    task automatic pulse(input int ch, input bit on_b);
        @(posedge core_clk);
        if (on_b)
            b[ch] <= 1'b1;
        else
            a[ch] <= 1'b1;
        repeat (HOLD) @(posedge core_clk);
        a[ch] <= 1'b0;
        b[ch] <= 1'b0;
        repeat (HOLD) @(posedge core_clk);
    endtask
endmodule // qec_enc_model

// ===== verification/qec_top_sva.sv
`timescale 1ns/1ps
module qec_top_sva (
    // clock, reset, enable
    input wire logic core_clk,
    input wire logic reset,
    input wire logic ce,
    // register port
    input wire logic [qec_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [qec_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [qec_pkg::DATA_W-1:0] reg_rdata,
    // outputs
    input wire logic [qec_pkg::QEC_NUM_CH-1:0] match_out,
    input wire logic irq
);
    import qec_pkg::*;
    // shadow of the mask and a pulse-width-is-zero flag, tracked from the bus
    logic [STAT_W-1:0] mask_sh;
    logic pw0;
    always_ff @(posedge core_clk) begin
        if (reset) begin
            mask_sh <= RST_MASK;
            pw0 <= 1'b1;
        end else if (ce && reg_wr) begin
            if (reg_addr == OFS_MASK)
                mask_sh <= reg_wdata[STAT_W-1:0];
            if (reg_addr == OFS_PWIDTH)
                pw0 <= (reg_wdata == '0);
        end
    end
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);
    rdata_idle_a: assert property ($past(ce) && !$past(reg_rd) |-> reg_rdata == '0)
        else $error("read data not zero outside a read");
    unmapped_zero_a: assert property ($past(reg_rd && reg_addr == 8'hFC) |-> reg_rdata == '0)
        else $error("unmapped read not zero");
    status_hi_a: assert property ($past(reg_rd && reg_addr == OFS_STATUS) |->
        reg_rdata[DATA_W-1:STAT_W] == '0) else $error("status upper bits set");
    inputs_match_a: assert property ($past(reg_rd && reg_addr == OFS_INPUTS) |->
        reg_rdata[7:4] == $past(match_out) && reg_rdata[DATA_W-1:8] == '0)
        else $error("inputs register wrong");
    irq_fall_a: assert property ($fell(irq) |-> $past(reg_rd && reg_addr == OFS_STATUS) ||
        $past(reg_wr && reg_addr == OFS_MASK)) else $error("irq fell without clear");
    match_irq_a: assert property (|(match_out & ~$past(match_out) & mask_sh[QEC_NUM_CH-1:0])
        |-> irq) else $error("match did not raise irq");
    irq_masked_a: assert property (irq |-> mask_sh != '0)
        else $error("irq with all sources masked");
    short_pulse_a: assert property (pw0 && $past(pw0) && |match_out |=>
        (match_out & $past(match_out)) == '0) else $error("zero width pulse too long");
    cover property ($rose(match_out[3]));
    cover property ($rose(irq));
    cover property (irq && reg_rd && reg_addr == OFS_STATUS);
endmodule // qec_top_sva
bind qec_top qec_top_sva chk_u (.core_clk(core_clk), .reset(reset), .ce(ce),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .match_out(match_out), .irq(irq));

// ===== verification/tb.sv
`timescale 1ns/1ps
module tb;
    import qec_pkg::*;
    localparam int TU = 10;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic ce = 1'b1;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [DATA_W-1:0] reg_rdata;
    logic [3:0] src = 4'h0;
    logic [3:0] dpa, dpb, dz, dg, tpa, tpb, tz, tg, match_out;
    logic irq;
    int n_mismatch = 0;
    int n_checks = 0;
    int pulses = 0;
    qec_top #(.TIMER_UNIT_CYCLES(TU)) dut_u (.core_clk(core_clk), .reset(reset), .ce(ce),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .diff_phase_a(dpa), .diff_phase_b(dpb),
        .diff_index_clear_input(dz), .diff_gp_in(dg), .ttl_phase_a(tpa), .ttl_phase_b(tpb),
        .ttl_index_clear_input(tz), .ttl_gp_in(tg), .match_out(match_out), .irq(irq));
    qec_enc_model enc_u (.core_clk(core_clk), .src(src), .diff_phase_a(dpa),
        .diff_phase_b(dpb), .diff_index_clear_input(dz), .diff_gp_in(dg), .ttl_phase_a(tpa),
        .ttl_phase_b(tpb), .ttl_index_clear_input(tz), .ttl_gp_in(tg));
    initial forever #2.5 core_clk = ~core_clk;
    always @(posedge core_clk) if (match_out[3] === 1'b1) pulses <= pulses + 1;
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp,
        input logic [DATA_W-1:0] msk = '1);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata & msk, exp);
    endtask
    task automatic wait_irq(input logic lev);
        int i;
        for (i = 0; i < 200 && irq !== lev; i++) begin
            @(posedge core_clk);
            #1;
        end
        if (irq !== lev) begin
            n_mismatch++;
            $display("mismatch at %0t: irq wait ran out", $time);
            give_verdict();
        end
    endtask
    task automatic t_reset();
        rd(OFS_CTRL, 32'h0);
        rd(OFS_PERIOD, 32'h3E8);
        rd(OFS_MASK, 32'h0);
        rd(OFS_COUNT, 32'h0);
        rd(8'hFC, 32'h0);
        $display("test reset done");
    endtask
    task automatic t_count();
        int k;
        @(posedge core_clk);
        src <= 4'h2;
        wr(OFS_CTRL, 32'h2);
        for (k = 0; k < 4; k++) enc_u.step(0, 1'b1);
        rd(OFS_COUNT, 32'h4);
        for (k = 0; k < 6; k++) enc_u.step(0, 1'b0);
        rd(OFS_COUNT, 32'hFFFFFE);
        for (k = 0; k < 3; k++) enc_u.step(1, 1'b1);
        rd(OFS_COUNT + 8'h04, 32'h3);
        // with the enable low the filter must not see the new level
        @(posedge core_clk);
        ce <= 1'b0;
        enc_u.step(1, 1'b1);
        ce <= 1'b1;
        rd(OFS_COUNT + 8'h04, 32'h3);
        repeat (40) @(posedge core_clk);
        rd(OFS_COUNT + 8'h04, 32'h4);
        wr(OFS_CTRL, 32'h42);
        wr(OFS_COUNT + 8'h08, 32'hFFFFFF);
        rd(OFS_COUNT + 8'h08, 32'hFFFFFF);
        enc_u.pulse(2, 1'b0);
        rd(OFS_COUNT + 8'h08, 32'h0);
        enc_u.pulse(2, 1'b1);
        enc_u.pulse(2, 1'b1);
        rd(OFS_COUNT + 8'h08, 32'hFFFFFE);
        $display("test count done");
    endtask
    task automatic t_clear_filter();
        @(posedge core_clk);
        enc_u.z[0] <= 1'b1;
        repeat (40) @(posedge core_clk);
        enc_u.step(0, 1'b1);
        rd(OFS_COUNT, 32'h0);
        @(posedge core_clk);
        enc_u.z[0] <= 1'b0;
        wr(OFS_FILTER, 32'h2);
        // let the clear fall through the wider filter before the glitch
        repeat (80) @(posedge core_clk);
        enc_u.a[0] <= ~enc_u.a[0];
        repeat (40) @(posedge core_clk);
        rd(OFS_COUNT, 32'h0);
        @(posedge core_clk);
        enc_u.a[0] <= ~enc_u.a[0];
        repeat (100) @(posedge core_clk);
        rd(OFS_COUNT, 32'h0);
        enc_u.step(0, 1'b1);
        rd(OFS_COUNT, 32'h1);
        wr(OFS_FILTER, 32'h3FFF);
        rd(OFS_FILTER, 32'h2940);
        wr(OFS_FILTER, 32'h0);
        wr(OFS_PWIDTH, 32'h3FFF);
        rd(OFS_PWIDTH, 32'h28CD);
        wr(OFS_PWIDTH, 32'h0);
        $display("test clear and filter done");
    endtask
    task automatic t_match();
        int p0;
        int w;
        rd(OFS_STATUS, 32'h0, 32'h0);
        wr(OFS_COMPARE + 8'h0C, 32'h2);
        wr(OFS_MASK, 32'h08);
        p0 = pulses;
        enc_u.step(3, 1'b1);
        #1;
        chk({31'h0, irq}, 32'h0);
        enc_u.step(3, 1'b1);
        #1;
        chk(32'(pulses - p0), 32'h1);
        chk({31'h0, irq}, 32'h1);
        rd(OFS_STATUS, 32'h08);
        wait_irq(1'b0);
        rd(OFS_STATUS, 32'h0);
        // two 10 us units: the free base makes the first unit short
        wr(OFS_PWIDTH, 32'h2);
        enc_u.step(3, 1'b0);
        p0 = pulses;
        enc_u.step(3, 1'b1);
        repeat (4000) @(posedge core_clk);
        #1;
        w = pulses - p0;
        chk(32'(w >= PULSE_UNIT_CYC + 2 && w <= 2 * PULSE_UNIT_CYC + 1), 32'h1);
        rd(OFS_STATUS, 32'h08);
        wr(OFS_MASK, 32'h0);
        $display("test match done");
    endtask
    task automatic t_timer_gp();
        wr(OFS_PERIOD, 32'h0);
        rd(OFS_PERIOD, 32'h1);
        wr(OFS_PERIOD, 32'h30D41);
        rd(OFS_PERIOD, 32'h30D40);
        wr(OFS_PERIOD, 32'h3);
        wr(OFS_MASK, 32'h10);
        wr(OFS_CTRL, 32'h142);
        wait_irq(1'b1);
        rd(OFS_STATUS, 32'h10);
        wr(OFS_CTRL, 32'h42);
        wr(OFS_MASK, 32'h0);
        enc_u.g[1] <= 1'b1;
        repeat (40) @(posedge core_clk);
        rd(OFS_INPUTS, 32'h2);
        $display("test timer and input done");
    endtask
    initial begin
        repeat (12) @(posedge core_clk);
        reset <= 1'b0;
        t_reset();
        t_count();
        t_clear_filter();
        t_match();
        t_timer_gp();
        give_verdict();
    end
endmodule // tb
